// ===== ulbg_top.sv
`timescale 1ns/10ps
`include "ulbg_defs.svh"
module ulbg_top
	import ulbg_pkg::*;
(
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_n,
	// control
	input  wire logic       unit_power_on,
	input  wire logic       tx_enable_bit,
	input  wire logic       rx_enable_bit,
	input  wire logic [3:0] base_clock_select,
	input  wire logic [7:0] divisor_value,
	input  wire logic [2:0] break_length_select,
	input  wire logic       break_send_set,
	input  wire logic       break_receive_set,
	input  wire logic       timer_output_source,
	// transmit data stream
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready,
	// receive data stream
	output logic [7:0]      rx_holding_reg,
	output logic            rx_valid,
	input  wire logic       rx_ready,
	// status
	output logic            break_send_trigger,
	output logic            break_receive_enable,
	output logic            break_receive_flag,
	output logic [2:0]      rx_error_status_reg,
	output logic            tx_done_irq,
	output logic            rx_done_irq,
	// line
	input  wire logic       serial_in_pin,
	output logic            serial_out_pin
);
	// ******************************
	// reset synchroniser
	// ******************************
	logic rst_s1_q, rst_s2_q;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	wire logic srst_n = rst_s2_q;
	// ******************************
	// base clock prescaler
	// ******************************
	logic [9:0] pre_q;
	logic       tmr_q;
	logic       tick;
	always_ff @(posedge mclk or negedge srst_n) begin
		if (!srst_n) begin
			pre_q <= 10'h000;
			tmr_q <= 1'b0;
		end else begin
			pre_q <= unit_power_on ? pre_q + 10'h001 : 10'h000;
			tmr_q <= timer_output_source;
		end
	end
	function automatic logic div_tick(input logic [3:0] sel, input logic [9:0] p);
		logic [10:0] m;
		m = (11'h001 << sel) - 11'h001;
		div_tick = ((p & m[9:0]) == m[9:0]);
	endfunction
	always_comb begin
		if (!unit_power_on)
			tick = 1'b0;
		else if (base_clock_select <= `ULBG_TPS_MAX_DIV)
			tick = div_tick(base_clock_select, pre_q);
		else if (base_clock_select == `ULBG_TPS_TIMER)
			tick = timer_output_source & ~tmr_q;
		else
			tick = 1'b0;
	end

	// ******************************
	// noise filter
	// ******************************
	logic [1:0] flt_q;
	logic       rxd_q;
	always_ff @(posedge mclk or negedge srst_n) begin
		if (!srst_n) begin
			flt_q <= 2'b11;
			rxd_q <= 1'b1;
		end else if (tick) begin
			flt_q <= {flt_q[0], serial_in_pin};
			if (flt_q[1] == flt_q[0])
				rxd_q <= flt_q[1];
		end
	end

	// ******************************
	// transmit buffer
	// ******************************
	logic [7:0] buf_q [`ULBG_BUF_DEPTH];
	logic       wp_q, rp_q;
	logic [1:0] cnt_q;
	logic       buf_pop;
	wire logic  buf_push = tx_valid & tx_ready;
	assign tx_ready = (cnt_q != 2'h2);
	always_ff @(posedge mclk or negedge srst_n) begin
		if (!srst_n) begin
			wp_q  <= 1'b0;
			rp_q  <= 1'b0;
			cnt_q <= 2'h0;
			buf_q[0] <= 8'h00;
			buf_q[1] <= 8'h00;
		end else begin
			if (buf_push) begin
				buf_q[wp_q] <= tx_data;
				wp_q        <= ~wp_q;
			end
			if (buf_pop)
				rp_q <= ~rp_q;
			cnt_q <= cnt_q + {1'b0, buf_push} - {1'b0, buf_pop};
		end
	end
	// ******************************
	// transmitter
	// ******************************
	ulbg_tx_state_t tx_st_q;
	logic [7:0]  tx_cnt_q;
	logic        tx_half_q;
	logic [4:0]  tx_bits_q;
	logic [9:0]  tx_sh_q;
	wire logic   tx_on   = unit_power_on & tx_enable_bit;
	// match at count k-1 (every k ticks), two halves a bit
	wire logic   tx_match = tick & (tx_cnt_q == divisor_value - 8'h01);
	wire logic   tx_bit  = tx_match & tx_half_q;
	wire logic   tx_load = tx_on & (tx_st_q == ULBG_TX_IDLE) & (cnt_q != 2'h0) & ~break_send_trigger;
	assign buf_pop = tx_load;
	always_ff @(posedge mclk or negedge srst_n) begin
		if (!srst_n) begin
			tx_cnt_q  <= 8'h00;
			tx_half_q <= 1'b0;
		end else if (!tx_on || tx_load) begin
			tx_cnt_q  <= 8'h00;
			tx_half_q <= 1'b0;
		end else if (tx_match) begin
			tx_cnt_q  <= 8'h00;
			tx_half_q <= ~tx_half_q;
		end else if (tick) begin
			tx_cnt_q  <= tx_cnt_q + 8'h01;
		end
	end
	always_ff @(posedge mclk or negedge srst_n) begin
		if (!srst_n) begin
			tx_st_q            <= ULBG_TX_IDLE;
			tx_bits_q          <= 5'h00;
			tx_sh_q            <= 10'h3ff;
			break_send_trigger <= 1'b0;
			tx_done_irq        <= 1'b0;
			serial_out_pin     <= 1'b1;
		end else begin
			tx_done_irq <= 1'b0;
			if (break_send_set && tx_on)
				break_send_trigger <= 1'b1;
			if (!tx_on) begin
				tx_st_q        <= ULBG_TX_IDLE;
				serial_out_pin <= 1'b1;
			end else begin
				case (tx_st_q)
					ULBG_TX_IDLE: begin
						serial_out_pin <= 1'b1;
						if (break_send_trigger && tx_bit) begin
							tx_st_q        <= ULBG_TX_BREAK;
							tx_bits_q      <= `ULBG_BRK_BASE + {2'b00, break_length_select};
							serial_out_pin <= 1'b0;
						end else if (tx_load) begin
							tx_st_q   <= ULBG_TX_FRAME;
							tx_sh_q   <= {1'b1, buf_q[rp_q], 1'b0};
							tx_bits_q <= {1'b0, `ULBG_FRAME_BITS};
						end
					end
					ULBG_TX_BREAK: begin
						if (tx_bit) begin
							tx_bits_q <= tx_bits_q - 5'h01;
							if (tx_bits_q == 5'h01) begin
								tx_st_q            <= ULBG_TX_IDLE;
								serial_out_pin     <= 1'b1;
								tx_done_irq        <= 1'b1;
								break_send_trigger <= break_send_set;
							end
						end
					end
					ULBG_TX_FRAME: begin
						if (tx_half_q == 1'b0 && tx_cnt_q == 8'h00)
							serial_out_pin <= tx_sh_q[0];
						if (tx_bit) begin
							tx_sh_q   <= {1'b1, tx_sh_q[9:1]};
							tx_bits_q <= tx_bits_q - 5'h01;
							if (tx_bits_q == 5'h01) begin
								tx_st_q     <= ULBG_TX_IDLE;
								tx_done_irq <= 1'b1;
							end
						end
					end
					default: tx_st_q <= ULBG_TX_IDLE;
				endcase
			end
		end
	end
	// ******************************
	// receiver
	// ******************************
	ulbg_rx_state_t rx_st_q;
	logic [7:0] rx_cnt_q;
	logic       rx_half_q;
	logic [4:0] rx_bits_q;
	logic [7:0] rx_shift_reg;
	logic       rxd_d1_q;
	logic       rx_full_q;
	wire logic  rx_on    = unit_power_on & rx_enable_bit;
	wire logic  rx_match = tick & (rx_cnt_q == divisor_value - 8'h01);
	wire logic  rx_fall  = rxd_d1_q & ~rxd_q;
	wire logic  brk_mode = rx_on & break_receive_enable;
	always_ff @(posedge mclk or negedge srst_n) begin
		if (!srst_n) begin
			rx_cnt_q  <= 8'h00;
			rx_half_q <= 1'b0;
		end else if (!rx_on || rx_st_q == ULBG_RX_IDLE) begin
			rx_cnt_q  <= 8'h00;
			rx_half_q <= 1'b0;
		end else if (rx_match) begin
			rx_cnt_q  <= 8'h00;
			rx_half_q <= ~rx_half_q;
		end else if (tick) begin
			rx_cnt_q  <= rx_cnt_q + 8'h01;
		end
	end
	always_ff @(posedge mclk or negedge srst_n) begin
		if (!srst_n) begin
			rx_st_q              <= ULBG_RX_IDLE;
			rx_bits_q            <= 5'h00;
			rx_shift_reg         <= 8'h00;
			rxd_d1_q             <= 1'b1;
			rx_holding_reg       <= `ULBG_HOLD_RESET;
			rx_full_q            <= 1'b0;
			rx_error_status_reg  <= 3'b000;
			break_receive_enable <= 1'b0;
			break_receive_flag   <= 1'b0;
			rx_done_irq          <= 1'b0;
		end else begin
			rx_done_irq <= 1'b0;
			rxd_d1_q    <= rxd_q;
			if (rx_valid && rx_ready)
				rx_full_q <= 1'b0;
			if (break_receive_set && rx_on) begin
				break_receive_enable <= 1'b1;
				break_receive_flag   <= 1'b1;
			end
			if (!rx_on) begin
				rx_st_q <= ULBG_RX_IDLE;
			end else begin
				case (rx_st_q)
					ULBG_RX_IDLE: begin
						if (rx_fall)
							rx_st_q <= ULBG_RX_START;
					end
					ULBG_RX_START: begin
						if (rx_match && !rx_half_q) begin
							rx_st_q   <= rxd_q ? ULBG_RX_IDLE : ULBG_RX_DATA;
							rx_bits_q <= 5'h01;
						end
					end
					ULBG_RX_DATA: begin
						if (rx_match && !rx_half_q) begin
							rx_bits_q <= rx_bits_q + 5'h01;
							if (rx_bits_q <= {1'b0, `ULBG_DATA_BITS})
								rx_shift_reg <= {rxd_q, rx_shift_reg[7:1]};
							// first high sample ends the low width
							if (brk_mode && rxd_q) begin
								rx_st_q <= ULBG_RX_IDLE;
								if (rx_bits_q >= `ULBG_BRK_RX_MIN) begin
									rx_done_irq          <= 1'b1;
									break_receive_enable <= break_receive_set;
									break_receive_flag   <= break_receive_set;
								end
								// short low: no irq; never flags or copy
							end else if (!brk_mode && rx_bits_q == {1'b0, `ULBG_DATA_BITS} + 5'h01) begin
								rx_st_q     <= ULBG_RX_IDLE;
								rx_done_irq <= 1'b1;
								rx_error_status_reg[2] <= ~rxd_q;
								rx_error_status_reg[0] <= rx_full_q & ~rx_ready;
								if (!rx_full_q || rx_ready) begin
									rx_holding_reg <= rx_shift_reg;
									rx_full_q      <= 1'b1;
								end
							end
						end
					end
					default: rx_st_q <= ULBG_RX_IDLE;
				endcase
			end
		end
	end
	assign rx_valid = rx_full_q;

	// ******************************
	// checks
	// ******************************
	default clocking @(posedge mclk); endclocking
	default disable iff (!srst_n);
	idle_high_a: assert property (!tx_on |=> serial_out_pin)
		else $error("output not idle high");
	brk_start_a: assert property ($rose(tx_st_q == ULBG_TX_BREAK) |-> !serial_out_pin)
		else $error("break did not drive low");
	brk_low_a: assert property (tx_st_q == ULBG_TX_BREAK && $past(tx_st_q == ULBG_TX_BREAK) |-> !serial_out_pin)
		else $error("break not held low");
	brk_end_a: assert property ($fell(tx_st_q == ULBG_TX_BREAK) && $past(tx_on) |-> tx_done_irq)
		else $error("no done at break end");
	tx_zero_a: assert property (!tx_on |=> tx_cnt_q == 8'h00)
		else $error("tx counter not zero");
	rx_zero_a: assert property (!rx_on |=> rx_cnt_q == 8'h00)
		else $error("rx counter not zero");
	brk_nocopy_a: assert property (brk_mode && rx_st_q == ULBG_RX_DATA |=> $stable(rx_holding_reg))
		else $error("break copied");
	brk_noerr_a: assert property (brk_mode && rx_st_q == ULBG_RX_DATA |=> $stable(rx_error_status_reg))
		else $error("error flag in break");
	gate_clk_a: assert property (!unit_power_on |-> !tick)
		else $error("base clock not gated");
	brk_tx_c: cover property ($fell(break_send_trigger));
	brk_rx_c: cover property (rx_done_irq && brk_mode);
	rx_byte_c: cover property (rx_valid && rx_ready);
endmodule

// ===== ulbg_defs.svh
`ifndef ULBG_DEFS_SVH
`define ULBG_DEFS_SVH
// ******************************
// clock select codes
// ******************************
`define ULBG_TPS_MAX_DIV    4'ha
`define ULBG_TPS_TIMER      4'hb
// ******************************
// divisor, break timing, frame sizes, hold reset value and buffer depth
// ******************************
`define ULBG_K_MIN          8'h08
`define ULBG_BRK_BASE       5'h0d
`define ULBG_BRK_RX_MIN     5'h0b
`define ULBG_DATA_BITS      4'h8
`define ULBG_FRAME_BITS     4'ha
`define ULBG_HOLD_RESET     8'hff
`define ULBG_BUF_DEPTH      2
`endif

// ===== ulbg_pkg.sv
package ulbg_pkg;
	typedef enum logic [1:0] {ULBG_TX_IDLE, ULBG_TX_BREAK, ULBG_TX_FRAME} ulbg_tx_state_t;
	typedef enum logic [1:0] {ULBG_RX_IDLE, ULBG_RX_START, ULBG_RX_DATA} ulbg_rx_state_t;
endpackage

// ===== ulbg_line_node.sv
`timescale 1ns/10ps
// ****************
// remote serial node
// ****************
module ulbg_line_node (
	// clock and timing
	input  wire logic   mclk,
	input  wire integer bit_len,
	// line
	input  wire logic   line_in,
	output logic        line_out
);
	logic [7:0] got [$];
	logic [7:0] sh;

	initial line_out = 1'b1;

	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		@(posedge mclk);
		for (int i = 0; i < 10; i++) begin
			#1 line_out = f[i];
			repeat (bit_len) @(posedge mclk);
		end
	endtask

	task automatic send_low(input int n);
		@(posedge mclk);
		#1 line_out = 1'b0;
		repeat (n * bit_len) @(posedge mclk);
		#1 line_out = 1'b1;
		repeat (bit_len) @(posedge mclk);
	endtask

	// samples each bit in its middle
	always begin
		@(negedge line_in);
		repeat (bit_len / 2) @(posedge mclk);
		if (line_in === 1'b0) begin
			for (int i = 0; i < 8; i++) begin
				repeat (bit_len) @(posedge mclk);
				sh[i] = line_in;
			end
			repeat (bit_len) @(posedge mclk);
			got.push_back(sh);
		end
	end
endmodule

// ===== ulbg_top_tb.sv
`timescale 1ns/10ps
module ulbg_top_tb
	import ulbg_pkg::*;
;
	// ****************
	// signals
	// ****************
	logic       mclk     = 1'b0;
	logic       rst_n    = 1'b0;
	logic       pwr      = 1'b1;
	logic       txe      = 1'b0;
	logic       rxe      = 1'b0;
	logic       tmr      = 1'b0;
	logic [3:0] cs       = 4'h0;
	logic [7:0] tx_data  = 8'h00;
	logic [2:0] len      = 3'h0;
	logic [7:0] kdiv     = 8'h08;
	logic       bs_set   = 1'b0;
	logic       br_set   = 1'b0;
	logic       tx_valid = 1'b0;
	logic       rx_ready = 1'b0;
	wire logic  tx_ready, rx_valid, bs_trig, br_en, br_flag, tx_irq, rx_irq, sin, sout;
	wire logic [7:0] rx_hold;
	wire logic [2:0] rx_err;
	int         n_errors = 0;
	int         n_checks = 0;
	int         n_tx     = 0;
	int         n_rx     = 0;
	int         bit_len  = 16;

	always #2.5 mclk = ~mclk;
	always @(posedge mclk) tmr <= #1 ~tmr;
	always @(negedge mclk) begin
		if (tx_irq === 1'b1) n_tx++;
		if (rx_irq === 1'b1) n_rx++;
	end

	ulbg_top DUT (
		.mclk(mclk), .rst_n(rst_n), .unit_power_on(pwr), .tx_enable_bit(txe), .rx_enable_bit(rxe),
		.base_clock_select(cs), .divisor_value(kdiv), .break_length_select(len),
		.break_send_set(bs_set), .break_receive_set(br_set), .timer_output_source(tmr),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_holding_reg(rx_hold),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .break_send_trigger(bs_trig),
		.break_receive_enable(br_en), .break_receive_flag(br_flag), .rx_error_status_reg(rx_err),
		.tx_done_irq(tx_irq), .rx_done_irq(rx_irq), .serial_in_pin(sin), .serial_out_pin(sout)
	);

	ulbg_line_node node (.mclk(mclk), .bit_len(bit_len), .line_in(sout), .line_out(sin));

	// ****************
	// helpers
	// ****************
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic results();
		if (n_errors == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ****************
	// scenarios
	// ****************
	task automatic t_idle();
		check("idle_out", 16'h1, {15'h0, sout});
		check("hold_reset", 16'h0ff, {7'h0, rx_valid, rx_hold});
		check("flags", 16'h0, {13'h0, bs_trig, br_en, br_flag});
	endtask

	task automatic t_refused();
		bs_set = 1'b1;
		br_set = 1'b1;
		tick(1);
		bs_set = 1'b0;
		br_set = 1'b0;
		tick(40);
		check("no_break", 16'h1, {14'h0, bs_trig, sout});
		check("no_brk_rx", 16'h0, {14'h0, br_en, br_flag});
		pwr = 1'b0;
		txe = 1'b1;
		rxe = 1'b1;
		bs_set = 1'b1;
		br_set = 1'b1;
		tick(1);
		bs_set = 1'b0;
		br_set = 1'b0;
		tick(8);
		check("pwr_off", 16'h1, {13'h0, bs_trig, br_en, sout});
		pwr = 1'b1;
		txe = 1'b0;
		rxe = 1'b0;
		tick(4);
	endtask

	task automatic t_break_tx(input logic [3:0] c, input logic [2:0] l);
		int lo;
		int n0;
		cs = c;
		len = l;
		txe = 1'b1;
		n0 = n_tx;
		lo = 0;
		bit_len = (2 * int'(kdiv)) << ((c == 4'hb) ? 1 : int'(c));
		tick(bit_len);
		bs_set = 1'b1;
		tick(1);
		bs_set = 1'b0;
		for (int i = 0; i < 3 * bit_len && sout === 1'b1; i++) tick(1);
		check("trigger", 16'h1, {15'h0, bs_trig});
		while (sout === 1'b0 && lo < 8000) begin
			tick(1);
			lo++;
		end
		check("break_low", 16'((13 + int'(l)) * bit_len), 16'(lo));
		tick(4);
		check("trigger_clr", 16'h0, {15'h0, bs_trig});
		check("tx_irq", 16'(n0 + 1), 16'(n_tx));
		tick(3 * bit_len);
		check("after_break", 16'h1, {15'h0, sout});
	endtask

	task automatic t_bad_code();
		int n0;
		n0 = n_tx;
		cs = 4'hc;
		bs_set = 1'b1;
		tick(1);
		bs_set = 1'b0;
		tick(100);
		check("bad_code", 16'h3, {14'h0, bs_trig, sout});
		cs = 4'h0;
		tick(30 * 2 * int'(kdiv));
		check("bad_code_end", 16'(n0 + 1), 16'(n_tx));
		check("bad_code_trig", 16'h0, {15'h0, bs_trig});
	endtask

	task automatic t_break_rx();
		int n0;
		rxe = 1'b1;
		n0 = n_rx;
		br_set = 1'b1;
		tick(1);
		br_set = 1'b0;
		tick(2);
		check("brk_on", 16'h3, {14'h0, br_en, br_flag});
		node.send_low(10);
		tick(12 * bit_len);
		check("short_irq", 16'(n0), 16'(n_rx));
		check("short_bits", 16'h3, {14'h0, br_en, br_flag});
		node.send_low(11);
		tick(4 * bit_len);
		check("long_irq", 16'(n0 + 1), 16'(n_rx));
		check("long_bits", 16'h0, {14'h0, br_en, br_flag});
		check("brk_err", 16'h0, {13'h0, rx_err});
		check("brk_hold", 16'h0ff, {7'h0, rx_valid, rx_hold});
	endtask

	task automatic t_rx_stream();
		node.send_byte(8'h11);
		node.send_byte(8'h22);
		node.send_byte(8'h33);
		tick(2 * bit_len);
		check("overrun", 16'h1, {15'h0, rx_err[0]});
		check("rx_1", 16'h111, {7'h0, rx_valid, rx_hold});
		rx_ready = 1'b1;
		tick(1);
		rx_ready = 1'b0;
		tick(1);
		check("rx_2", 16'h011, {7'h0, rx_valid, rx_hold});
		node.send_byte(8'h44);
		tick(2 * bit_len);
		check("rx_3", 16'h144, {7'h0, rx_valid, rx_hold});
		check("rx_frame", 16'h0, {13'h0, rx_err});
		rx_ready = 1'b1;
		tick(1);
		rx_ready = 1'b0;
		tick(1);
		check("rx_empty", 16'h0, {15'h0, rx_valid});
	endtask

	task automatic t_tx_stream();
		logic [7:0] w [4];
		logic       full;
		w = '{8'ha5, 8'h3c, 8'h0f, 8'hf0};
		full = 1'b0;
		kdiv = 8'h09;
		bit_len = 2 * int'(kdiv);
		node.got.delete();
		tx_valid = 1'b1;
		foreach (w[i]) begin
			tx_data = w[i];
			for (int g = 0; g < 4000 && tx_ready !== 1'b1; g++) begin
				full = 1'b1;
				tick(1);
			end
			tick(1);
		end
		tx_valid = 1'b0;
		tick(40 * bit_len);
		check("tx_full", 16'h1, {15'h0, full});
		check("tx_count", 16'h4, 16'(node.got.size()));
		foreach (w[i])
			if (i < node.got.size()) check("tx_word", {8'h0, w[i]}, {8'h0, node.got[i]});
	endtask

	// ****************
	// sequence
	// ****************
	initial begin
		tick(16);
		rst_n = 1'b1;
		tick(4);
		t_idle();
		t_refused();
		t_break_tx(4'h0, 3'h0);
		t_break_tx(4'h1, 3'h7);
		t_break_tx(4'hb, 3'h2);
		t_bad_code();
		cs = 4'h0;
		bit_len = 16;
		t_break_rx();
		t_rx_stream();
		t_tx_stream();
		results();
	end

	initial begin
		#100000;
		n_errors++;
		results();
	end
endmodule
